// *** core/adc_seq_map.svh ***
// widths, field positions, reset values and timing counts of the converter control port
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define RES_W          12
`define SEQ_DEPTH      16
`define SEQ_PTR_W      4
`define ENTRY_W        7
// entry layout: {input type, address[2:0], polarity, gain, last}
`define ENT_TYPE_BIT   6
`define ENT_ADDR_HI    5
`define ENT_ADDR_LO    3
`define ENT_POL_BIT    2
`define ENT_GAIN_BIT   1
`define ENT_LAST_BIT   0
`define ENTRY_RST      7'h00
`define PTR_RST        4'h0
`define PIN_SYNC_W     13
`define PIN_SYNC_RST   13'h1fff

`define CLK_PERIOD_NS  20
`define CONV_TIME_NS   2000
// longest time, rounded down to whole cycles
`define CONV_CYC       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W          7

`endif

// *** core/adc_seq_pkg.sv ***
// types shared by the converter control port
`default_nettype none
`include "adc_seq_map.svh"
package adc_seq_pkg;

  typedef struct packed {
    logic       input_type_select;
    logic [2:0] addr;
    logic       pol;
    logic       gain;
    logic       last;
  } seq_entry_t;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_SCAN,
    MODE_PROG,
    MODE_SEQ
  } op_mode_t;

  typedef enum logic {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

  typedef struct packed {
    conv_state_t          st;
    logic [`CNT_W-1:0]    cnt;
    logic [`SEQ_PTR_W-1:0] ptr;
    logic [2:0]           scan;
    seq_entry_t           dcfg;
    seq_entry_t           ccfg;
    seq_entry_t           tag;
    logic [`RES_W-1:0]    res;
    logic                 wr_d;
    logic                 rd_d;
    logic                 cv_d;
    logic                 prog_d;
    logic [`RES_W-1:0]    dout;
    logic                 tdiff;
    logic [2:0]           taddr;
    logic                 oe;
  } state_t;

endpackage
`default_nettype wire

// *** core/mux_adc_parallel_sequencer_port.sv ***
// control, sequencer and parallel result port of the eight-channel sampling converter
`default_nettype none
`include "adc_seq_map.svh"
module mux_adc_parallel_sequencer_port
  import adc_seq_pkg::*;
(
  input  wire logic              mclk_i,                 // 50 MHz system clock
  input  wire logic              rst_n_i,                // async reset, active low
  input  wire logic [2:0]        channel_address_in_i,   // mux address pins
  input  wire logic              input_type_select_i,    // 1 differential, 0 single-ended
  input  wire logic              gain_select_i,          // 1 gain one, 0 gain two
  input  wire logic              polarity_select_i,      // 1 bipolar, 0 unipolar
  input  wire logic              wr_n_i,                 // write strobe, active low
  input  wire logic              rd_n_i,                 // read strobe, active low
  input  wire logic              cs_n_i,                 // chip select, active low
  input  wire logic              conversion_start_n_i,   // start on falling edge
  input  wire logic              power_down_n_i,         // shutdown, active low
  input  wire logic              mode_select_lo_i,       // mode pin zero
  input  wire logic              mode_select_hi_i,       // mode pin one
  input  wire logic [`RES_W-1:0] conv_data_i,            // converter core result
  output logic      [`RES_W-1:0] data_o,                 // result bus
  output logic                   data_oe_o,              // result bus enable
  output logic                   tag_input_type_out_o,   // type tag pin
  output logic      [2:0]        tag_address_out_o,      // address tag pins
  output logic                   busy_n_o,               // low while converting or programming
  output logic      [2:0]        mux_address_o,          // analog mux channel
  output logic                   mux_input_type_select_o,             // pair mode to analog front end
  output logic                   common_neg_en_o,        // common input in use
  output logic                   gain_two_o,             // front end gain of two
  output logic                   bipolar_o,              // bipolar span
  output logic                   sample_o,               // one-cycle hold pulse
  output logic                   nap_o,                  // nap power state
  output logic                   sleep_o                 // sleep power state
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`PIN_SYNC_W-1:0] pins_s;
  logic [2:0] addr_s;
  logic       input_type_select_s, gain_s, pol_s, wr_s, rd_s, cs_s, cv_s, pd_s, m0_s, m1_s;

  pin_sync #(.W(`PIN_SYNC_W), .RST_VAL(`PIN_SYNC_RST)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i ({channel_address_in_i, input_type_select_i, gain_select_i,
               polarity_select_i, wr_n_i, rd_n_i, cs_n_i, conversion_start_n_i,
               power_down_n_i, mode_select_lo_i, mode_select_hi_i}),
    .sync_o  (pins_s)
  );

  assign {addr_s, input_type_select_s, gain_s, pol_s, wr_s, rd_s, cs_s, cv_s, pd_s, m0_s, m1_s} = pins_s;

  // ************************************************************
  // mode decode and sequencer memory
  // ************************************************************
  function automatic op_mode_t mode_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00:   mode_of = MODE_DIRECT;
      2'b01:   mode_of = MODE_SCAN;
      2'b10:   mode_of = MODE_PROG;
      default: mode_of = MODE_SEQ;
    endcase
  endfunction

  state_t     s_r, s_nxt;
  op_mode_t   mode;
  seq_entry_t pin_cfg, mem_rd, acq_cfg;
  logic       prog, asleep, wr_rise, rd_rise, cv_fall, start, done, mem_we;

  assign mode    = mode_of(m1_s, m0_s);
  assign prog    = (mode == MODE_PROG);
  assign asleep  = !pd_s;
  assign pin_cfg = '{input_type_select: input_type_select_s, addr: addr_s, pol: pol_s, gain: gain_s, last: 1'b0};
  assign wr_rise = wr_s && !s_r.wr_d;
  assign rd_rise = rd_s && !s_r.rd_d && !cs_s;
  assign cv_fall = !cv_s && s_r.cv_d && !cs_s;
  assign mem_we  = prog && wr_rise;
  // a start during a running conversion, programming or shutdown is dropped
  assign start   = cv_fall && (s_r.st == CONV_IDLE) && !prog && !asleep;
  assign done    = (s_r.st == CONV_RUN) && (s_r.cnt == `CNT_W'(`CONV_CYC - 1));

  seq_store u_store (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .we_i    (mem_we),
    .addr_i  (s_r.ptr),
    .wdata_i (pin_cfg),
    .rdata_o (mem_rd)
  );

  // configuration for the channel now being acquired
  always_comb begin
    acq_cfg = wr_s ? s_r.dcfg : pin_cfg;
    case (mode)
      MODE_SCAN: acq_cfg.addr = s_r.scan;
      MODE_SEQ:  acq_cfg = mem_rd;
      default:   ;
    endcase
  end

  // ************************************************************
  // state update
  // ************************************************************
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wr_d   = wr_s;
    s_nxt.rd_d   = rd_s;
    s_nxt.cv_d   = cv_s;
    s_nxt.prog_d = prog;
    if (!wr_s) begin
      s_nxt.dcfg = pin_cfg;
    end
    // pointer restarts whenever program mode is entered or left
    if (prog != s_r.prog_d) begin
      s_nxt.ptr = `PTR_RST;
    end else if (mem_we || (prog && rd_rise)) begin
      s_nxt.ptr = s_r.ptr + `SEQ_PTR_W'(1);
    end else if (start && mode == MODE_SEQ) begin
      s_nxt.ptr = mem_rd.last ? `PTR_RST : s_r.ptr + `SEQ_PTR_W'(1);
    end
    if (start && mode == MODE_SCAN) begin
      s_nxt.scan = s_r.scan + 3'h1;
    end
    case (s_r.st)
      CONV_IDLE: begin
        if (start) begin
          s_nxt.st   = CONV_RUN;
          s_nxt.cnt  = '0;
          s_nxt.ccfg = acq_cfg;
        end
      end
      CONV_RUN: begin
        s_nxt.cnt = s_r.cnt + `CNT_W'(1);
        if (done) begin
          s_nxt.st  = CONV_IDLE;
          s_nxt.res = conv_data_i;
          s_nxt.tag = s_r.ccfg;
        end
      end
      default: s_nxt.st = CONV_IDLE;
    endcase
    // registered bus drivers
    s_nxt.oe = !rd_s && !cs_s;
    if (prog) begin
      s_nxt.dout  = {mem_rd.pol, mem_rd.gain, mem_rd.last, {(`RES_W-3){1'b0}}};
      s_nxt.tdiff = mem_rd.input_type_select;
      s_nxt.taddr = mem_rd.addr;
    end else begin
      s_nxt.dout  = s_r.res;
      s_nxt.tdiff = s_r.tag.input_type_select;
      s_nxt.taddr = s_r.tag.addr;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: CONV_IDLE, ptr: `PTR_RST, wr_d: 1'b1, rd_d: 1'b1, cv_d: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // next configuration reaches the front end at the start edge: its channel acquires meanwhile
  seq_entry_t front;
  assign front = acq_cfg;

  assign data_o               = s_r.dout;
  assign data_oe_o            = s_r.oe;
  assign tag_input_type_out_o = s_r.tdiff;
  assign tag_address_out_o    = s_r.taddr;
  assign busy_n_o             = (s_r.st == CONV_IDLE) && !prog;
  assign mux_address_o        = front.addr;
  assign mux_input_type_select_o           = front.input_type_select;
  assign common_neg_en_o      = !front.input_type_select;
  assign gain_two_o           = !front.gain;
  assign bipolar_o            = front.pol;
  assign sample_o             = start;
  assign nap_o                = asleep && !cs_s;
  assign sleep_o              = asleep && cs_s;

  // ************************************************************
  // checks
  // ************************************************************
  chk_busy_span: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start |=> (!busy_n_o [*8]) ##[0:120] (s_r.st == CONV_IDLE))
    else $error("busy did not span the conversion");

  chk_conv_len: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start |-> ##101 (s_r.st == CONV_IDLE) && $past(s_r.st == CONV_RUN))
    else $error("conversion length wrong");

  chk_prog_busy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    prog |-> !busy_n_o)
    else $error("busy released in program mode");

  chk_bus_enable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    data_oe_o |-> $past(!rd_s && !cs_s))
    else $error("bus driven without read and select");

  chk_start_cs: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cs_s && (s_r.st == CONV_IDLE) |=> (s_r.st == CONV_IDLE))
    else $error("conversion started without select");

  chk_result_tag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done |=> (s_r.tag == $past(s_r.ccfg)) && (s_r.res == $past(conv_data_i)))
    else $error("result or tag not captured");

  chk_prog_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mem_we && (prog == s_r.prog_d) |=> s_r.ptr == $past(s_r.ptr) + `SEQ_PTR_W'(1))
    else $error("pointer did not advance on write");

  chk_seq_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start && mode == MODE_SEQ && mem_rd.last && (prog == s_r.prog_d) |=> s_r.ptr == `PTR_RST)
    else $error("sequence did not wrap after last entry");

  chk_power_state: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pd_s |-> (nap_o != sleep_o) && (nap_o == !cs_s))
    else $error("power state wrong");

  chk_readback_top: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    prog && $past(prog) |-> data_o[`RES_W-1 -: 3] == $past({mem_rd.pol, mem_rd.gain, mem_rd.last}))
    else $error("readback fields misplaced");

  chk_common_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    common_neg_en_o != mux_input_type_select_o)
    else $error("common input state disagrees with pair mode");

  chk_direct_type: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode == MODE_DIRECT) && !wr_s |-> (mux_input_type_select_o == input_type_select_s) && (mux_address_o == addr_s))
    else $error("type or address not passed through");

  chk_direct_gain: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode == MODE_DIRECT) && !wr_s |-> gain_two_o == !gain_s)
    else $error("gain select not passed through");

  chk_direct_span: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode == MODE_DIRECT) && !wr_s |-> bipolar_o == pol_s)
    else $error("polarity select not passed through");

  chk_direct_latch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode == MODE_DIRECT) && wr_rise
      |-> {mux_input_type_select_o, mux_address_o} == $past({input_type_select_s, addr_s}))
    else $error("write edge did not latch the configuration");

  chk_latch_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_s |=> $stable(s_r.dcfg))
    else $error("latched configuration moved while write high");

  chk_start_take: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start |=> !busy_n_o && (s_r.ccfg == $past(acq_cfg)))
    else $error("start edge not taken");

  chk_busy_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !prog && (s_r.st == CONV_IDLE) |-> busy_n_o)
    else $error("busy held low outside conversion and programming");

  chk_scan_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start && (mode == MODE_SCAN) |=> (s_r.scan == $past(s_r.scan) + 3'h1)
      && ((mode != MODE_SCAN) || (mux_address_o == s_r.scan)))
    else $error("scan address did not move on at the start");

  chk_seq_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start && (mode == MODE_SEQ) && !mem_rd.last && (prog == s_r.prog_d)
      |=> s_r.ptr == $past(s_r.ptr) + `SEQ_PTR_W'(1))
    else $error("sequence did not step to the next entry");

  chk_readback_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    prog && rd_rise && (prog == s_r.prog_d) |=> s_r.ptr == $past(s_r.ptr) + `SEQ_PTR_W'(1))
    else $error("read release did not advance the pointer");

  chk_readback_tag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    prog && $past(prog) |-> {tag_input_type_out_o, tag_address_out_o} == $past({mem_rd.input_type_select, mem_rd.addr}))
    else $error("readback tags wrong");

  chk_result_bus: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !prog && !$past(prog) |-> data_o == $past(s_r.res))
    else $error("result bus does not carry the result");

  chk_conv_tag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !prog && !$past(prog) |-> {tag_input_type_out_o, tag_address_out_o} == $past({s_r.tag.input_type_select, s_r.tag.addr}))
    else $error("conversion tags wrong");

  chk_start_refused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    asleep || prog || (s_r.st == CONV_RUN) |-> !start)
    else $error("start taken while refused");

  chk_oe_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_s && !cs_s |=> data_oe_o)
    else $error("bus not driven during read");
endmodule // mux_adc_parallel_sequencer_port
`default_nettype wire

// *** core/pin_sync.sv ***
// two-flop synchroniser for the asynchronous host pins
`default_nettype none
module pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,   // system clock
  input  wire logic         rst_n_i,  // async reset, active low
  input  wire logic [W-1:0] async_i,  // raw pins
  output logic      [W-1:0] sync_o    // synchronised copy
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // pin_sync
`default_nettype wire

// *** core/seq_store.sv ***
// sixteen-entry sequencer memory, one write port and one read port
`default_nettype none
`include "adc_seq_map.svh"
module seq_store
  import adc_seq_pkg::*;
(
  input  wire logic                  mclk_i,   // system clock
  input  wire logic                  rst_n_i,  // async reset, active low
  input  wire logic                  we_i,     // write strobe
  input  wire logic [`SEQ_PTR_W-1:0] addr_i,   // entry index
  input  wire seq_entry_t            wdata_i,  // entry to store
  output seq_entry_t                 rdata_o   // entry at addr_i
);
  seq_entry_t mem_r [`SEQ_DEPTH];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `SEQ_DEPTH; i++) begin
        mem_r[i] <= `ENTRY_RST;
      end
    end else if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_r[addr_i];
endmodule // seq_store
`default_nettype wire

// *** dv/host_model.sv ***
// host-side model driving the converter's parallel control pins
`default_nettype none
module host_model #(
  parameter int WAKE_CYC = 10  // wake wait after nap; sleep needs far longer
) (
  input  wire logic       mclk_i,    // system clock
  input  wire logic       busy_n_i,  // busy from device
  output logic      [2:0] addr_o,    // channel address pins
  output logic            type_o,    // input type select
  output logic            gain_o,    // gain select
  output logic            pol_o,     // polarity select
  output logic            wr_n_o,    // write strobe
  output logic            rd_n_o,    // read strobe
  output logic            cs_n_o,    // chip select
  output logic            start_n_o, // conversion start
  output logic            pd_n_o,    // shutdown
  output logic            m_lo_o,    // mode pin zero
  output logic            m_hi_o     // mode pin one
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_o, type_o, gain_o, pol_o} = 6'h00;
    {wr_n_o, rd_n_o, cs_n_o, start_n_o, pd_n_o} = 5'h1f;
    {m_hi_o, m_lo_o} = 2'h0;
  end
  task automatic set_cfg(input logic [2:0] a, input logic d, input logic g, input logic p);
    @(negedge mclk_i);
    {addr_o, type_o, gain_o, pol_o} = {a, d, g, p};
    wr_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    wr_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
    // pins no longer qualified: inverse, so a missed latch shows up
    {addr_o, type_o, gain_o, pol_o} = ~{a, d, g, p};
  endtask
  task automatic convert(input logic cs, output int low);
    int n;
    n = 0;
    low = 0;
    @(negedge mclk_i);
    cs_n_o = cs;
    @(negedge mclk_i);
    start_n_o = 1'b0;
    while (busy_n_i === 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    while (busy_n_i === 1'b0 && low < 300) begin
      @(negedge mclk_i);
      low++;
    end
    start_n_o = 1'b1;
    cs_n_o = 1'b1;
  endtask
  task automatic rd_low(input logic cs);
    @(negedge mclk_i);
    cs_n_o = cs;
    @(negedge mclk_i);
    rd_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic rd_high();
    rd_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
  endtask
  task automatic set_mode(input logic hi, input logic lo);
    @(negedge mclk_i);
    m_hi_o = hi;
    @(negedge mclk_i);
    m_lo_o = lo;
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic power(input logic pd, input logic cs);
    @(negedge mclk_i);
    cs_n_o = cs;
    @(negedge mclk_i);
    pd_n_o = pd;
    repeat (4) @(negedge mclk_i);
    if (pd) repeat (WAKE_CYC) @(negedge mclk_i);
  endtask
endmodule // host_model
`default_nettype wire

// *** dv/test_mux_adc_parallel_sequencer_port.sv ***
// self-checking bench of the converter control port
`default_nettype none
`include "adc_seq_map.svh"
module test_mux_adc_parallel_sequencer_port;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  a;
    logic        d;
    logic        g;
    logic        p;
    logic [11:0] c;
  } row_t;
  logic mclk_i, rst_n_i, wr_n, rd_n, cs_n, st_n, pd_n, m_lo, m_hi, typ, gain, pol, oe, tdiff, busy_n;
  logic mdiff, comn, g2, bip, nap, slp, smp;
  logic [2:0] addr, taddr, maddr;
  logic [11:0] conv_data, dout;
  int bad_count, num_checks, cyc, low, n_smp;
  row_t rows [4] = '{'{3'h0, 1'b0, 1'b1, 1'b0, 12'h000}, '{3'h7, 1'b1, 1'b0, 1'b1, 12'hfff},
                     '{3'h5, 1'b0, 1'b0, 1'b1, 12'ha5c}, '{3'h2, 1'b1, 1'b1, 1'b0, 12'h3c1}};
  mux_adc_parallel_sequencer_port dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .channel_address_in_i(addr),
    .input_type_select_i(typ), .gain_select_i(gain), .polarity_select_i(pol), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .cs_n_i(cs_n), .conversion_start_n_i(st_n), .power_down_n_i(pd_n), .mode_select_lo_i(m_lo),
    .mode_select_hi_i(m_hi), .conv_data_i(conv_data), .data_o(dout), .data_oe_o(oe),
    .tag_input_type_out_o(tdiff), .tag_address_out_o(taddr), .busy_n_o(busy_n), .mux_address_o(maddr),
    .mux_input_type_select_o(mdiff), .common_neg_en_o(comn), .gain_two_o(g2), .bipolar_o(bip), .sample_o(smp),
    .nap_o(nap), .sleep_o(slp));
  host_model host (.mclk_i(mclk_i), .busy_n_i(busy_n), .addr_o(addr), .type_o(typ), .gain_o(gain),
    .pol_o(pol), .wr_n_o(wr_n), .rd_n_o(rd_n), .cs_n_o(cs_n), .start_n_o(st_n), .pd_n_o(pd_n),
    .m_lo_o(m_lo), .m_hi_o(m_hi));
  // ****
  // checking and closing
  // ****
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rb_check(input logic [11:0] d, input logic t, input logic [2:0] a);
    host.rd_low(1'b0);
    check("readback data", dout, d);
    check("readback type", {11'h000, tdiff}, {11'h000, t});
    check("readback addr", {9'h000, taddr}, {9'h000, a});
    host.rd_high();
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // an accepted start shows as exactly one hold pulse
  always @(negedge mclk_i) begin
    if (smp === 1'b1) begin
      n_smp++;
    end
  end
  // ceiling well above the roughly 1,000 cycles the tests need
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rst_n_i = 1'b0;
    conv_data = 12'h000;
    repeat (4) @(negedge mclk_i);
    check("reset busy", {11'h000, busy_n}, 12'h001);
    check("reset oe", {9'h000, oe, nap, slp}, 12'h000);
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    foreach (rows[i]) begin
      host.set_cfg(rows[i].a, rows[i].d, rows[i].g, rows[i].p);
      check("front end", {7'h00, maddr, mdiff, comn, g2, bip},
            {7'h00, rows[i].a, rows[i].d, ~rows[i].d, ~rows[i].g, rows[i].p});
      conv_data = rows[i].c;
      host.convert(1'b0, low);
      check("busy length", low[11:0], 12'(`CONV_CYC));
      check("sample pulse", n_smp[11:0], 12'(i + 1));
      check("idle oe", {11'h000, oe}, 12'h000);
      host.rd_low(1'b0);
      check("oe", {11'h000, oe}, 12'h001);
      check("result", dout, rows[i].c);
      check("tags", {8'h00, tdiff, taddr}, {8'h00, rows[i].d, rows[i].a});
      host.rd_high();
      check("released oe", {11'h000, oe}, 12'h000);
      $display("row %0d done", i);
    end
    host.convert(1'b1, low);
    check("deselected start", low[11:0], 12'h000);
    check("deselected pulse", n_smp[11:0], 12'h004);
    host.rd_low(1'b1);
    check("deselected read", {11'h000, oe}, 12'h000);
    host.rd_high();
    $display("deselect test done");
    host.set_mode(1'b1, 1'b0);
    check("program busy", {11'h000, busy_n}, 12'h000);
    host.set_cfg(3'h3, 1'b1, 1'b0, 1'b1);
    host.set_cfg(3'h6, 1'b0, 1'b1, 1'b0);
    check("program busy held", {11'h000, busy_n}, 12'h000);
    host.set_mode(1'b1, 1'b1);
    check("busy released", {11'h000, busy_n}, 12'h001);
    host.set_mode(1'b1, 1'b0);
    rb_check(12'h800, 1'b1, 3'h3);
    rb_check(12'h400, 1'b0, 3'h6);
    $display("program test done");
    host.set_mode(1'b0, 1'b1);
    check("scan first", {9'h000, maddr}, 12'h000);
    for (int k = 0; k < 2; k++) begin
      conv_data = 12'h5a0 + 12'(k);
      host.convert(1'b0, low);
      check("scan busy", low[11:0], 12'(`CONV_CYC));
      check("scan next", {9'h000, maddr}, 12'(k + 1));
      host.rd_low(1'b0);
      check("scan tag", {9'h000, taddr}, 12'(k));
      check("scan result", dout, 12'h5a0 + 12'(k));
      host.rd_high();
    end
    host.set_mode(1'b1, 1'b1);
    check("seq first", {6'h00, maddr, mdiff, comn, g2, bip}, {6'h00, 3'h3, 1'b1, 1'b0, 1'b1, 1'b1});
    conv_data = 12'h9c3;
    host.convert(1'b0, low);
    check("seq busy", low[11:0], 12'(`CONV_CYC));
    check("seq next", {9'h000, maddr}, 12'h006);
    host.rd_low(1'b0);
    check("seq tag", {8'h00, tdiff, taddr}, 12'h00b);
    check("seq result", dout, 12'h9c3);
    host.rd_high();
    check("sample pulses", n_smp[11:0], 12'h007);
    host.set_mode(1'b0, 1'b0);
    $display("scan and sequence test done");
    host.power(1'b0, 1'b0);
    check("nap", {10'h000, nap, slp}, 12'h002);
    host.power(1'b0, 1'b1);
    check("sleep", {10'h000, nap, slp}, 12'h001);
    host.power(1'b1, 1'b1);
    check("awake", {10'h000, nap, slp}, 12'h000);
    $display("shutdown test done");
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    check("mid reset", {10'h000, busy_n, oe}, 12'h002);
    rst_n_i = 1'b1;
    $display("reset test done");
    test_done();
  end
endmodule // test_mux_adc_parallel_sequencer_port
`default_nettype wire
